// ### inc/intc_pkg.sv
// Functional notes
// [R01] wakeup pin falling edge sets its flag
// [R02] wakeup enable bit zero blocks wakeup requests
// [R03] all wakeup pins share vector nine
// [R04] edge select picks each external pin edge
// [R05] selected external edge sets external flag
// [R06] external pins vectors four to eight, ordered
// [R07] twenty peripheral flags, enables, vectors ten-twenty
// [R08] mask bit one blocks every source
// [R09] acceptance sets the mask bit
// [R10] flags set only while source enabled; wakeup and [R20] function-switch flags are set regardless of ien1
// [R11] highest priority pending wins, others wait
// [R12] accept only when mask bit clear
// [R13] stack counter and codes after instruction
// [R14] fetch vector, start handler there
// [R15] response timing four, two, four, four
// [R16] clear colliding with request still serviced
// [R17] software clears only while masked
// [R18] word accesses force address bit zero
// [R19] codes stacked as word, even byte restored
// [R20] external function switch low sets flag
// [R21] wakeup function enable while low sets flag
// [R22] clear right after function write ignored
// [R23] flags cleared only by writing zero
// [R24] edge select zero falling, one rising
`default_nettype none
package intc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IEN1 = 8'h00;
  localparam logic [7:0] OFS_IEN2 = 8'h04;
  localparam logic [7:0] OFS_IFL1 = 8'h08;
  localparam logic [7:0] OFS_IFL2 = 8'h0c;
  localparam logic [7:0] OFS_WKF = 8'h10;
  localparam logic [7:0] OFS_ESEL = 8'h14;
  localparam logic [7:0] OFS_PF1 = 8'h18;
  localparam logic [7:0] OFS_PF2 = 8'h1c;
  localparam logic [7:0] OFS_PF5 = 8'h20;
  localparam logic [7:0] OFS_CCR = 8'h24;
  localparam logic [7:0] OFS_STAT = 8'h28;
  localparam int WKEN_BIT = 5;
  localparam int IBIT = 7;
  localparam logic [7:0] CCR_RST = 8'h80;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // vectors and response timing in states
  // ----------------------------------------------------------------
  localparam logic [4:0] VEC_EXT0 = 5'h04;
  localparam logic [4:0] VEC_WAKE = 5'h09;
  localparam logic [4:0] VEC_PER0 = 5'h0a;
  localparam int PER_VECS = 11;
  localparam logic [3:0] STACK_ST = 4'h4;
  localparam logic [3:0] VECF_ST = 4'h2;
  localparam logic [3:0] IFETCH_ST = 4'h4;
  localparam logic [3:0] INTRN_ST = 4'h4;
  localparam logic [15:0] WORD_BYTES = 16'h0002;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_STACK, ST_VEC, ST_IFETCH, ST_INTRN
  } seq_t;

  typedef struct packed {
    logic insn_done;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] vec_data;
    logic return_from_exception;
    logic [15:0] rte_word;
  } cpu_in_t;

  typedef struct packed {
    logic stack_we;
    logic vec_rd;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic go;
    logic [15:0] handler_pc;
    logic [15:0] sp_new;
    logic ibit;
  } cpu_out_t;
endpackage
`default_nettype wire

// ### logic/intc_core.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`default_nettype none
module intc_core #(
  parameter int N_WAKE = 8,
  parameter int N_EXT = 5,
  parameter int N_PER = 20
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_wakeup_pins,
  input wire logic [4:0] i_ext_request_pins,
  input wire logic [19:0] i_periph_evt,
  input wire intc_pkg::cpu_in_t i_cpu,
  output intc_pkg::cpu_out_t o_cpu,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import intc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_t state;
    logic [3:0] cnt;
    logic [4:0] vec;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] ccr_saved;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ien1;
    logic [19:0] ien2;
    logic [4:0] ifl1;
    logic [19:0] ifl2;
    logic [7:0] wkf;
    logic [4:0] esel;
    logic [7:0] pf1;
    logic [7:0] pf2;
    logic [7:0] pf5;
    logic [7:0] condition_code_reg;
    logic pf_recent;
    logic [7:0] wk_s1;
    logic [7:0] wk_s2;
    logic [7:0] wk_s3;
    logic [4:0] ex_s1;
    logic [4:0] ex_s2;
    logic [4:0] ex_s3;
    logic [4:0] ext_fn_d;
    logic [7:0] wk_fn_d;
    cpu_out_t cpu;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [4:0] per_vec(input int i);
    per_vec = VEC_PER0 + 5'((i * PER_VECS) / N_PER);
  endfunction

  function automatic logic [31:0] bmask(input logic [3:0] strb);
    bmask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nv, input logic [3:0] strb);
    merge = (old & ~bmask(strb)) | (nv & bmask(strb));
  endfunction

  logic [4:0] ext_fn;
  logic [4:0] ext_set;
  logic [7:0] wk_set;
  logic [19:0] per_set;
  logic sel_ok;
  logic [4:0] sel_vec;
  logic wr_go;
  logic [31:0] m;
  logic [7:0] st_code;

  assign ext_fn = {s_r.pf2[4], s_r.pf1[3:1], s_r.pf2[0]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    sel_ok = 1'b0;
    sel_vec = 5'h00;
    m = 32'h0000_0000;
    st_code = 8'h00;
    // pin synchronisers, edge detection reads only stages 2 and 3
    s_nxt.wk_s1 = i_wakeup_pins;
    s_nxt.wk_s2 = s_r.wk_s1;
    s_nxt.wk_s3 = s_r.wk_s2;
    s_nxt.ex_s1 = i_ext_request_pins;
    s_nxt.ex_s2 = s_r.ex_s1;
    s_nxt.ex_s3 = s_r.ex_s2;
    for (int i = 0; i < N_WAKE; i++) begin
      // [R01] wakeup falling edge
      wk_set[i] = s_r.pf5[i] && s_r.wk_s3[i] && !s_r.wk_s2[i];
      // [R21] wakeup enable while low
      if (s_r.pf5[i] && !s_r.wk_fn_d[i] && !s_r.wk_s2[i]) begin
        wk_set[i] = 1'b1;
      end
    end
    for (int i = 0; i < N_EXT; i++) begin
      // [R04] [R24] edge choice per pin
      // [R05] [R10] enabled edge sets flag
      ext_set[i] = s_r.ien1[i] && ext_fn[i] && (s_r.esel[i] ?
          (!s_r.ex_s3[i] && s_r.ex_s2[i]) :
          (s_r.ex_s3[i] && !s_r.ex_s2[i]));
      // [R20] function switch while low
      if (!s_r.ex_s2[i] && ((ext_fn[i] && !s_r.ext_fn_d[i] &&
          !s_r.esel[i]) || (!ext_fn[i] && s_r.ext_fn_d[i] &&
          s_r.esel[i]))) begin
        ext_set[i] = 1'b1;
      end
    end
    // [R07] [R10] peripheral flags gated by enables
    per_set = i_periph_evt & s_r.ien2;
    s_nxt.ext_fn_d = ext_fn;
    s_nxt.wk_fn_d = s_r.pf5;

    // ---------------- register bus ----------------
    if (awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'b00;
      s_nxt.pf_recent = 1'b0;
      // [R23] zero clears, one keeps
      m = s_r.wdata | ~bmask(s_r.wstrb);
      if (s_r.awaddr == OFS_IEN1) begin
        s_nxt.ien1 = 6'(merge(32'(s_r.ien1), s_r.wdata, s_r.wstrb));
      end else if (s_r.awaddr == OFS_IEN2) begin
        s_nxt.ien2 = 20'(merge(32'(s_r.ien2), s_r.wdata, s_r.wstrb));
      end else if (s_r.awaddr == OFS_IFL1) begin
        // [R22] clear right after function write lost
        if (!s_r.pf_recent) s_nxt.ifl1 = s_r.ifl1 & m[4:0];
      end else if (s_r.awaddr == OFS_IFL2) begin
        s_nxt.ifl2 = s_r.ifl2 & m[19:0];
      end else if (s_r.awaddr == OFS_WKF) begin
        // [R22] same guard for wakeup flags
        if (!s_r.pf_recent) s_nxt.wkf = s_r.wkf & m[7:0];
      end else if (s_r.awaddr == OFS_ESEL) begin
        s_nxt.esel = 5'(merge(32'(s_r.esel), s_r.wdata, s_r.wstrb));
      end else if (s_r.awaddr == OFS_PF1) begin
        s_nxt.pf1 = 8'(merge(32'(s_r.pf1), s_r.wdata, s_r.wstrb));
        s_nxt.pf_recent = 1'b1;
      end else if (s_r.awaddr == OFS_PF2) begin
        s_nxt.pf2 = 8'(merge(32'(s_r.pf2), s_r.wdata, s_r.wstrb));
        s_nxt.pf_recent = 1'b1;
      end else if (s_r.awaddr == OFS_PF5) begin
        s_nxt.pf5 = 8'(merge(32'(s_r.pf5), s_r.wdata, s_r.wstrb));
        s_nxt.pf_recent = 1'b1;
      end else if (s_r.awaddr == OFS_CCR) begin
        s_nxt.condition_code_reg = 8'(merge(32'(s_r.condition_code_reg), s_r.wdata, s_r.wstrb));
      end else if (s_r.awaddr == OFS_STAT) begin
        s_nxt.bresp = 2'b00;
      end else begin
        s_nxt.bresp = 2'b10;
      end
    end
    // [R16] set wins over a colliding clear
    s_nxt.wkf = s_nxt.wkf | wk_set;
    s_nxt.ifl1 = s_nxt.ifl1 | ext_set;
    s_nxt.ifl2 = s_nxt.ifl2 | per_set;

    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    st_code = {s_r.state, s_r.vec};
    if (arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = 2'b00;
      if (araddr == OFS_IEN1) begin
        s_nxt.rdata = 32'(s_r.ien1);
      end else if (araddr == OFS_IEN2) begin
        s_nxt.rdata = 32'(s_r.ien2);
      end else if (araddr == OFS_IFL1) begin
        s_nxt.rdata = 32'(s_r.ifl1);
      end else if (araddr == OFS_IFL2) begin
        s_nxt.rdata = 32'(s_r.ifl2);
      end else if (araddr == OFS_WKF) begin
        s_nxt.rdata = 32'(s_r.wkf);
      end else if (araddr == OFS_ESEL) begin
        s_nxt.rdata = 32'(s_r.esel);
      end else if (araddr == OFS_PF1) begin
        s_nxt.rdata = 32'(s_r.pf1);
      end else if (araddr == OFS_PF2) begin
        s_nxt.rdata = 32'(s_r.pf2);
      end else if (araddr == OFS_PF5) begin
        s_nxt.rdata = 32'(s_r.pf5);
      end else if (araddr == OFS_CCR) begin
        s_nxt.rdata = 32'(s_r.condition_code_reg);
      end else if (araddr == OFS_STAT) begin
        s_nxt.rdata = 32'(st_code);
      end else begin
        s_nxt.rdata = REG_RST;
        s_nxt.rresp = 2'b10;
      end
    end

    // ---------------- priority select ----------------
    // [R11] scan lowest priority first, last hit wins
    for (int i = N_PER - 1; i >= 0; i--) begin
      if (s_r.ifl2[i] && s_r.ien2[i]) begin
        sel_ok = 1'b1;
        sel_vec = per_vec(i);
      end
    end
    // [R02] [R03] one shared wakeup vector
    if (|s_r.wkf && s_r.ien1[WKEN_BIT]) begin
      sel_ok = 1'b1;
      sel_vec = VEC_WAKE;
    end
    // [R06] pin 0 highest
    for (int i = N_EXT - 1; i >= 0; i--) begin
      if (s_r.ifl1[i] && s_r.ien1[i]) begin
        sel_ok = 1'b1;
        sel_vec = VEC_EXT0 + 5'(i);
      end
    end

    // ---------------- exception sequence ----------------
    s_nxt.cpu.stack_we = 1'b0;
    s_nxt.cpu.vec_rd = 1'b0;
    s_nxt.cpu.go = 1'b0;
    s_nxt.cnt = s_r.cnt + 4'h1;
    case (s_r.state)
      ST_IDLE: begin
        s_nxt.cnt = 4'h0;
        // [R08] [R12] mask bit holds requests pending
        if (sel_ok && !s_r.condition_code_reg[IBIT]) begin
          s_nxt.state = ST_WAIT;
          s_nxt.vec = sel_vec;
          s_nxt.ccr_saved = s_r.condition_code_reg;
          // [R09] mask further interrupts
          s_nxt.condition_code_reg[IBIT] = 1'b1;
        end
      end
      ST_WAIT: begin
        s_nxt.cnt = 4'h0;
        // [R13] wait for instruction end
        if (i_cpu.insn_done) begin
          s_nxt.state = ST_STACK;
          s_nxt.pc = i_cpu.pc;
          s_nxt.sp = i_cpu.sp;
        end
      end
      ST_STACK: begin
        // [R13] [R18] [R19] even-aligned word pushes
        if (s_r.cnt == 4'h0) begin
          s_nxt.cpu.stack_we = 1'b1;
          s_nxt.cpu.addr = (s_r.sp - WORD_BYTES) & 16'hfffe;
          s_nxt.cpu.wdata = s_r.pc;
        end else if (s_r.cnt == 4'h2) begin
          s_nxt.cpu.stack_we = 1'b1;
          s_nxt.cpu.addr = (s_r.sp - 16'(2 * WORD_BYTES)) & 16'hfffe;
          s_nxt.cpu.wdata = {s_r.ccr_saved, s_r.ccr_saved};
        end
        // [R15] stacking states
        if (s_r.cnt == STACK_ST - 4'h1) begin
          s_nxt.state = ST_VEC;
          s_nxt.cnt = 4'h0;
          s_nxt.cpu.sp_new = (s_r.sp - 16'(2 * WORD_BYTES)) & 16'hfffe;
        end
      end
      ST_VEC: begin
        // [R14] vector table read, one word per vector
        s_nxt.cpu.vec_rd = 1'b1;
        s_nxt.cpu.addr = {10'h000, s_r.vec, 1'b0};
        // [R15] vector fetch states
        if (s_r.cnt == VECF_ST - 4'h1) begin
          s_nxt.state = ST_IFETCH;
          s_nxt.cnt = 4'h0;
        end
      end
      ST_IFETCH: begin
        // [R14] handler address captured
        if (s_r.cnt == 4'h0) s_nxt.cpu.handler_pc = i_cpu.vec_data;
        if (s_r.cnt == IFETCH_ST - 4'h1) begin
          s_nxt.state = ST_INTRN;
          s_nxt.cnt = 4'h0;
        end
      end
      ST_INTRN: begin
        // [R15] internal states then handler starts
        if (s_r.cnt == INTRN_ST - 4'h1) begin
          s_nxt.state = ST_IDLE;
          s_nxt.cnt = 4'h0;
          s_nxt.cpu.go = 1'b1;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
    // [R19] return restores even byte only
    if (i_cpu.return_from_exception) s_nxt.condition_code_reg = i_cpu.rte_word[15:8];
    s_nxt.cpu.ibit = s_nxt.condition_code_reg[IBIT];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.condition_code_reg <= CCR_RST;
      s_r.cpu.ibit <= CCR_RST[IBIT];
      // pins idle high, so no false edge after reset
      s_r.wk_s1 <= 8'hff;
      s_r.wk_s2 <= 8'hff;
      s_r.wk_s3 <= 8'hff;
      s_r.ex_s1 <= 5'h1f;
      s_r.ex_s2 <= 5'h1f;
      s_r.ex_s3 <= 5'h1f;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_cpu = s_r.cpu;
  assign awready = !s_r.aw_got && !s_r.bvalid;
  assign wready = !s_r.w_got && !s_r.bvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = !s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_wake_edge_flag: assert property ( // [R01]
    (|(s_r.pf5 & s_r.wk_s3 & ~s_r.wk_s2))
    |=> &(s_r.wkf | ~$past(s_r.pf5 & s_r.wk_s3 & ~s_r.wk_s2)))
    else $error("wakeup edge did not set flag");
  a_wake_fn_flag: assert property ( // [R21]
    (|(s_r.pf5 & ~s_r.wk_fn_d & ~s_r.wk_s2))
    |=> &(s_r.wkf | ~$past(s_r.pf5 & ~s_r.wk_fn_d & ~s_r.wk_s2)))
    else $error("wakeup function switch did not set flag");
  a_ext_rise_flag: assert property ( // [R05]
    (s_r.ien1[1] && s_r.pf1[1] && s_r.esel[1] && !s_r.ex_s3[1] &&
     s_r.ex_s2[1]) |=> s_r.ifl1[1])
    else $error("rising edge did not set external flag");
  a_mask_blocks: assert property ( // [R08]
    (s_r.state == ST_IDLE && s_r.condition_code_reg[IBIT] && !i_cpu.return_from_exception)
    |=> s_r.state == ST_IDLE)
    else $error("accepted while masked");
  a_accept_masks: assert property ( // [R09]
    (s_r.state == ST_IDLE && s_nxt.state == ST_WAIT)
    |=> $past(i_cpu.return_from_exception) || (s_r.condition_code_reg[IBIT] && o_cpu.ibit))
    else $error("mask bit not set on accept");
  a_stack_even: assert property ( // [R18]
    (o_cpu.stack_we || o_cpu.vec_rd) |-> !o_cpu.addr[0])
    else $error("odd word address");
  a_vec_two: assert property ( // [R15]
    $rose(o_cpu.vec_rd) |-> o_cpu.vec_rd[*2] ##1 !o_cpu.vec_rd)
    else $error("vector fetch not two states");
  a_stack_to_go: assert property ( // [R15]
    ($rose(o_cpu.stack_we) && s_r.cnt == 4'h1) |-> ##13 o_cpu.go)
    else $error("handler start late or early");
  a_rte_even: assert property ( // [R19]
    i_cpu.return_from_exception |=> s_r.condition_code_reg == $past(i_cpu.rte_word[15:8]))
    else $error("return did not restore even byte");
  // lowest pending pin index must be the one taken
  a_prio_ext0: assert property ( // [R06]
    (s_r.state == ST_IDLE && !s_r.condition_code_reg[IBIT] && !i_cpu.return_from_exception &&
     (s_r.ifl1 & s_r.ien1[4:0]) != 5'h00)
    |=> ($past(s_r.ifl1 & s_r.ien1[4:0]) &
         ~($past(s_r.ifl1 & s_r.ien1[4:0]) - 5'h01)) ==
        5'(5'h01 << (s_r.vec - VEC_EXT0)))
    else $error("pin 0 not given top priority");

  c_wake_accept: cover property (
    s_r.state == ST_IDLE ##1 s_r.state == ST_WAIT && s_r.vec == VEC_WAKE);
  c_full_seq: cover property (o_cpu.go);
  c_masked_pending: cover property (s_r.condition_code_reg[IBIT] && |s_r.ifl2);
endmodule // intc_core
`default_nettype wire

// ### dv/cpu_model.sv
`default_nettype none
module cpu_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire intc_pkg::cpu_out_t i_cpu,
  input wire logic i_rte_req,
  input wire logic [15:0] i_rte_word,
  output intc_pkg::cpu_in_t o_cpu,
  output logic [15:0] o_pc_exp,
  output logic [15:0] o_a0,
  output logic [15:0] o_d0,
  output logic [15:0] o_a1,
  output logic [15:0] o_d1,
  output logic [7:0] o_go_cnt,
  output logic [7:0] o_go_lat,
  output logic [7:0] o_vrd
);
  timeunit 1ns;
  timeprecision 1ps;
  import intc_pkg::*;
  // ------------------------------------------------------------
  // instruction stream and stack memory view
  // ------------------------------------------------------------
  logic [2:0] cnt_r;
  logic [15:0] mark_r;
  logic busy_r;
  logic [7:0] lat_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 3'h0;
      mark_r <= 16'h0000;
      busy_r <= 1'b0;
      lat_r <= 8'h00;
      o_cpu <= '0;
      o_pc_exp <= 16'h0000;
      {o_a0, o_d0, o_a1, o_d1} <= '0;
      {o_go_cnt, o_go_lat, o_vrd} <= '0;
    end else begin
      // five-state instructions, odd stack pointer on purpose
      cnt_r <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
      o_cpu.insn_done <= (cnt_r == 3'h4);
      o_cpu.sp <= 16'h0ff1;
      if (o_cpu.insn_done) begin
        mark_r <= o_cpu.pc;
        o_cpu.pc <= o_cpu.pc + 16'h0002;
      end
      // vector word valid only in second read cycle and the state after it
      o_cpu.vec_data <= i_cpu.vec_rd ? (16'h8000 | i_cpu.addr)
                                     : ~o_cpu.vec_data;
      // return word, garbage outside the pulse
      o_cpu.return_from_exception <= i_rte_req;
      o_cpu.rte_word <= i_rte_req ? i_rte_word : ~o_cpu.rte_word;
      lat_r <= lat_r + 8'h01;
      if (i_cpu.stack_we) begin
        {o_a0, o_d0} <= {o_a1, o_d1};
        {o_a1, o_d1} <= {i_cpu.addr, i_cpu.wdata};
        if (!busy_r) begin
          busy_r <= 1'b1;
          lat_r <= 8'h01;
          o_vrd <= 8'h00;
          o_pc_exp <= mark_r;
        end
      end
      if (i_cpu.vec_rd) o_vrd <= o_vrd + 8'h01;
      if (i_cpu.go) begin
        busy_r <= 1'b0;
        o_go_cnt <= o_go_cnt + 8'h01;
        o_go_lat <= lat_r;
      end
    end
  end
endmodule // cpu_model
`default_nettype wire

// ### dv/test_mcu_interrupt_controller.sv
`default_nettype none
module test_mcu_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import intc_pkg::*;
  logic i_clk, i_rstn, rte_req;
  logic [7:0] wk, awaddr, araddr, go_cnt, go_lat, vrd;
  logic [4:0] ext, fl;
  logic [19:0] pev;
  logic [15:0] rte_word, pc_exp, a0, d0, a1, d1;
  cpu_in_t cin;
  cpu_out_t cout;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int error_cnt, num_checks;
  intc_core i_dut (.i_clk, .i_rstn, .i_wakeup_pins(wk),
    .i_ext_request_pins(ext), .i_periph_evt(pev), .i_cpu(cin),
    .o_cpu(cout), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  cpu_model i_cpu_model (.i_clk, .i_rstn, .i_cpu(cout), .i_rte_req(rte_req),
    .i_rte_word(rte_word), .o_cpu(cin), .o_pc_exp(pc_exp), .o_a0(a0),
    .o_d0(d0), .o_a1(a1), .o_d1(d1), .o_go_cnt(go_cnt),
    .o_go_lat(go_lat), .o_vrd(vrd));
  // ------------------------------------------------------------
  // bus tasks and checks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
    rs = rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rv);
  endtask
  task automatic return_from_exception(input logic [15:0] w);
    @(posedge i_clk);
    rte_req <= 1'b1;
    rte_word <= w;
    @(posedge i_clk);
    rte_req <= 1'b0;
  endtask
  task automatic wait_go(input logic [4:0] v);
    logic [7:0] g;
    logic [15:0] h;
    int n;
    g = go_cnt;
    n = 0;
    h = 16'h8000 | {10'h0, v, 1'b0};
    while (go_cnt === g && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    chk("go", 32'h1, 32'(n < 300));
    chk("handler", 32'(h), 32'(cout.handler_pc));
    chk("latency", 32'd13, 32'(go_lat));
    chk("vec_rd", 32'(VECF_ST), 32'(vrd));
    chk("pc_word", 32'(pc_exp), 32'(d0));
    chk("pc_addr", 32'h0fee, 32'(a0));
    chk("ccr_addr", 32'h0fec, 32'(a1));
    chk("sp_new", 32'h0fec, 32'(cout.sp_new));
    chk("ccr_word", 32'(d1[15:8]), 32'(d1[7:0]));
    chk("ccr_saved", 32'h0, 32'(d1[15:8]));
    chk("ibit", 32'h1, 32'(cout.ibit));
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    stop_test;
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    error_cnt = 0;
    num_checks = 0;
    i_rstn = 1'b0;
    {wk, ext, pev, rte_req, rte_word} = {8'hff, 5'h1f, 20'h0, 1'b0, 16'h0};
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    rchk(OFS_CCR, 32'h80);
    rd(8'h2c);
    chk("rresp", 32'h2, 32'(rs));
    wr(8'h2c, 32'h1);
    chk("bresp", 32'h2, 32'(rs));
    wr(OFS_IEN1, 32'h1f);
    wr(OFS_ESEL, 32'h0a);
    wr(OFS_PF1, 32'h0e);
    wr(OFS_PF2, 32'h11);
    ext <= 5'h00;
    repeat (6) @(posedge i_clk);
    rchk(OFS_IFL1, 32'h15);
    ext <= 5'h1f;
    repeat (6) @(posedge i_clk);
    rchk(OFS_IFL1, 32'h1f);
    wr(OFS_PF1, 32'h0e);
    wr(OFS_IFL1, 32'h0);
    rchk(OFS_IFL1, 32'h1f);
    wr(OFS_IFL1, 32'h1e);
    rchk(OFS_IFL1, 32'h1e);
    repeat (30) @(posedge i_clk);
    chk("masked go", 32'h0, 32'(go_cnt));
    wr(OFS_CCR, 32'h0);
    wait_go(5'h05);
    rchk(OFS_CCR, 32'h80);
    rchk(OFS_STAT, 32'(VEC_EXT0 + 5'h01));
    fl = 5'h1e;
    for (int i = 1; i < 5; i++) begin
      fl[i] = 1'b0;
      // cleared while masked
      wr(OFS_IFL1, 32'(fl));
      return_from_exception(16'h00ff);
      if (i < 4) wait_go(5'(5 + i));
    end
    rchk(OFS_CCR, 32'h0);
    wr(OFS_PF5, 32'hff);
    wk <= 8'hf7;
    repeat (6) @(posedge i_clk);
    rchk(OFS_WKF, 32'h08);
    chk("wake off", 32'h4, 32'(go_cnt));
    wr(OFS_IEN1, 32'h3f);
    wait_go(VEC_WAKE);
    wk <= 8'hff;
    wr(OFS_WKF, 32'h0);
    rchk(OFS_WKF, 32'h0);
    wr(OFS_PF5, 32'h0);
    wk <= 8'hfe;
    wr(OFS_PF5, 32'hff);
    repeat (6) @(posedge i_clk);
    rchk(OFS_WKF, 32'h01);
    wk <= 8'hff;
    wr(OFS_IEN2, 32'h1);
    wr(OFS_WKF, 32'h0);
    @(posedge i_clk);
    pev <= 20'h00003;
    @(posedge i_clk);
    pev <= 20'h0;
    repeat (3) @(posedge i_clk);
    rchk(OFS_IFL2, 32'h1);
    return_from_exception(16'h00ff);
    wait_go(5'h0a);
    wr(OFS_IEN2, 32'h80001);
    pev <= 20'h80000;
    @(posedge i_clk);
    pev <= 20'h0;
    wr(OFS_IFL2, 32'h80000);
    return_from_exception(16'h00ff);
    wait_go(5'h14);
    stop_test;
  end
endmodule // test_mcu_interrupt_controller
`default_nettype wire
